// [core/fscr_map.vh]
// Constants, command codes and field layout of the fault status and settings bank
// What this block does
// R1 - Hold remote inhibit mode: disabled, level-follow or edge-latched; host writes and reads it
// R2 - Hold one on/off bit enabling the external analog control input; readable
// R3 - Hold AC or DC coupling for external reference and DC level inputs; readable
// R4 - Hold start angle 0.0 to 359.9 degrees in tenths; zero after reset
// R5 - Hold stop angle 0.0 to 360.0; 360.0 means stop now
// R6 - Operation event query always answers zero
// R7 - Operation enable mask accepts 0 to 255 but always reads zero
// R8 - Read-only fault condition shows level_follow_block fault sources, 0 to 511
// R9 - Read-only fault event bits set only by filtered condition edges, 0 to 511
// R10 - Summary bit set when service enable bit set and masked events nonzero
// R11 - Fault event mask read/write 0 to 65535; only masked-in events reach summary
// R12 - Falling-edge select bit set: 1-to-0 condition change sets event bit
// R13 - Rising-edge select bit set: 0-to-1 condition change sets event bit
// R14 - Both select bits zero: no condition change ever sets that event bit
// R15 - Falling-edge select register read/write, accepts 0 to 65535
// R16 - Rising-edge select register read/write, accepts 0 to 511
// R17 - Fault bits: 8 overvolt, 7 line, 6 overcurrent, 5 fan, 4 short, 3 temp, 2 power, 1-0 inner
// R18 - Event bits stay set until event read or clear-status clears them
// R19 - After reset event, mask and edge selects are all zero
`ifndef FSCR_MAP_VH
`define FSCR_MAP_VH

// ----------------------------------------
// Command selector codes
// ----------------------------------------
`define FSCR_SEL_INHIBIT     4'h0
`define FSCR_SEL_EXTERNAL    4'h1
`define FSCR_SEL_COUPLING    4'h2
`define FSCR_SEL_PHASE_ON    4'h3
`define FSCR_SEL_PHASE_OFF   4'h4
`define FSCR_SEL_OPER_EVENT  4'h5
`define FSCR_SEL_OPER_MASK   4'h6
`define FSCR_SEL_FAULT_COND  4'h7
`define FSCR_SEL_FAULT_EVENT 4'h8
`define FSCR_SEL_FAULT_MASK  4'h9
`define FSCR_SEL_FALL_SEL    4'hA
`define FSCR_SEL_RISE_SEL    4'hB
`define FSCR_SEL_CLEAR       4'hC

// ----------------------------------------
// Inhibit modes and coupling values
// ----------------------------------------
`define FSCR_INH_DISABLED    2'h0
`define FSCR_INH_LEVEL       2'h1
`define FSCR_INH_EDGE        2'h2
`define FSCR_COUPLE_AC       1'h0
`define FSCR_COUPLE_DC       1'h1

// ----------------------------------------
// Accepted value limits (inclusive)
// ----------------------------------------
`define FSCR_INH_MAX         16'h0002
`define FSCR_BIN_MAX         16'h0001
`define FSCR_PH_ON_MAX       16'h0E0F
`define FSCR_PH_OFF_MAX      16'h0E10
`define FSCR_OPER_MAX        16'h00FF
`define FSCR_RISE_MAX        16'h01FF
`define FSCR_STOP_NOW        12'hE10

// ----------------------------------------
// Fault bit positions
// ----------------------------------------
`define FSCR_FLT_W           9
`define FSCR_BIT_OUT_OVERVOLT 8
`define FSCR_BIT_LINE_IN      7
`define FSCR_BIT_OVERCURRENT  6
`define FSCR_BIT_FAN_FAIL     5
`define FSCR_BIT_OUT_SHORT    4
`define FSCR_BIT_OVERTEMP     3
`define FSCR_BIT_OVERPOWER    2
`define FSCR_BIT_INNER_DCDC   1
`define FSCR_BIT_INNER_ACDC   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSCR_RST_INHIBIT     2'h0
`define FSCR_RST_EXTERNAL    1'h0
`define FSCR_RST_COUPLING    1'h0
`define FSCR_RST_PHASE       12'h000
`define FSCR_RST_FLT         9'h000
`define FSCR_RST_WORD        16'h0000

`endif

// [core/fscr_sync.v]
// Three-stage synchroniser with agreement filter for the fault source pins
`timescale 1ns/100ps
module fscr_sync (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  // Raw pins
  input  wire [8:0] i_pin,
  // Filtered level
  output reg  [8:0] o_level
);

  reg [8:0] stage1;
  reg [8:0] stage2;
  reg [8:0] stage3;

  // Shift chain; stage1 feeds only stage2
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= 9'h000;
      stage2 <= 9'h000;
      stage3 <= 9'h000;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once stage2 and stage3 agree
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level <= 9'h000;
    end else begin
      o_level <= (stage3 & ~(stage2 ^ stage3)) | (o_level & (stage2 ^ stage3));
    end
  end

endmodule // fscr_sync

// [core/fscr_edge.v]
// Per-bit rising and falling edge filter for fault conditions
`timescale 1ns/100ps
module fscr_edge (
  // Condition before and after
  input  wire [8:0] i_prev,
  input  wire [8:0] i_cur,
  // Edge selects
  input  wire [8:0] i_rise_sel,
  input  wire [8:0] i_fall_sel,
  // Event set vector
  output wire [8:0] o_set
);

  // Only selected directions pass; both selects zero passes nothing
  assign o_set = (~i_prev & i_cur & i_rise_sel)   // see R13, see R14
               | (i_prev & ~i_cur & i_fall_sel);  // see R12, see R14

endmodule // fscr_edge

// [core/fscr_regs.v]
// Settings and fault status register bank driven by a host command port
`timescale 1ns/100ps
`include "fscr_map.vh"
module fscr_regs (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  // Host command port
  input  wire        i_cmd_valid,
  input  wire        i_cmd_write,
  input  wire [3:0]  i_cmd_sel,
  input  wire [15:0] i_cmd_wdata,
  // Host answer port
  output reg         o_rsp_valid,
  output reg         o_rsp_err,
  output reg  [15:0] o_rsp_data,
  // Fault source pins
  input  wire [8:0]  i_fault_pin,
  // Service request enable bit from the status byte logic
  input  wire        i_srq_fault_en,
  // Settings to the instrument
  output reg  [1:0]  o_inhibit_mode,
  output reg         o_ext_ctl_en,
  output reg         o_coupling_dc,
  output reg  [11:0] o_phase_on,
  output reg  [11:0] o_phase_off,
  output reg         o_stop_now,
  // Status to the status byte logic
  output reg  [8:0]  o_fault_cond,
  output reg         o_fault_summary_bit
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Value lies within the inclusive limit
  function fscr_fits;
    input [15:0] value;
    input [15:0] limit;
    begin
      fscr_fits = (value <= limit);
    end
  endfunction

  // Zero-extend a fault vector to a word
  function [15:0] fscr_word9;
    input [8:0] value;
    begin
      fscr_word9 = {7'h00, value};
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [8:0]  fault_cond_d;
  reg  [8:0]  fault_event;
  reg  [15:0] fault_event_mask;
  reg  [15:0] fall_edge_select;
  reg  [8:0]  rise_edge_select;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire        wr_req;
  wire        rd_req;
  wire [8:0]  level_follow_block_cond;
  wire [8:0]  edge_set;
  reg         wr_inhibit;
  reg         wr_external;
  reg         wr_coupling;
  reg         wr_phase_on;
  reg         wr_phase_off;
  reg         wr_fault_mask;
  reg         wr_fall_sel;
  reg         wr_rise_sel;
  reg         clr_event;
  reg         next_err;
  reg  [15:0] next_data;
  reg  [8:0]  next_event;

  assign wr_req = i_cmd_valid & i_cmd_write;
  assign rd_req = i_cmd_valid & ~i_cmd_write;

  // ----------------------------------------
  // Fault source path
  // ----------------------------------------

  // Pin synchroniser and agreement filter
  fscr_sync u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_fault_pin),
    .o_level   (level_follow_block_cond)
  );

  // Direction filter on condition changes
  fscr_edge u_edge (
    .i_prev     (fault_cond_d),
    .i_cur      (level_follow_block_cond),
    .i_rise_sel (rise_edge_select),
    .i_fall_sel (fall_edge_select[8:0]),
    .o_set      (edge_set)
  );

  // Level_follow_block condition view and its previous value for edge detection
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fault_cond <= `FSCR_RST_FLT;
      fault_cond_d <= `FSCR_RST_FLT;
    end else begin
      o_fault_cond <= level_follow_block_cond;    // see R8, see R17
      fault_cond_d <= level_follow_block_cond;
    end
  end

  // ----------------------------------------
  // Command decode and range checks
  // ----------------------------------------

  // Write strobes, read data and error flag for one command
  always @* begin
    wr_inhibit    = 1'b0;
    wr_external   = 1'b0;
    wr_coupling   = 1'b0;
    wr_phase_on   = 1'b0;
    wr_phase_off  = 1'b0;
    wr_fault_mask = 1'b0;
    wr_fall_sel   = 1'b0;
    wr_rise_sel   = 1'b0;
    clr_event     = 1'b0;
    next_err      = 1'b0;
    next_data     = `FSCR_RST_WORD;
    case (i_cmd_sel)
      `FSCR_SEL_INHIBIT: begin
        next_data = {14'h0000, o_inhibit_mode};
        if (i_cmd_write) begin
          wr_inhibit = fscr_fits(i_cmd_wdata, `FSCR_INH_MAX);    // see R1
          next_err   = ~wr_inhibit;
        end
      end
      `FSCR_SEL_EXTERNAL: begin
        next_data = {15'h0000, o_ext_ctl_en};
        if (i_cmd_write) begin
          wr_external = fscr_fits(i_cmd_wdata, `FSCR_BIN_MAX);   // see R2
          next_err    = ~wr_external;
        end
      end
      `FSCR_SEL_COUPLING: begin
        next_data = {15'h0000, o_coupling_dc};
        if (i_cmd_write) begin
          wr_coupling = fscr_fits(i_cmd_wdata, `FSCR_BIN_MAX);   // see R3
          next_err    = ~wr_coupling;
        end
      end
      `FSCR_SEL_PHASE_ON: begin
        next_data = {4'h0, o_phase_on};
        if (i_cmd_write) begin
          wr_phase_on = fscr_fits(i_cmd_wdata, `FSCR_PH_ON_MAX); // see R4
          next_err    = ~wr_phase_on;
        end
      end
      `FSCR_SEL_PHASE_OFF: begin
        next_data = {4'h0, o_phase_off};
        if (i_cmd_write) begin
          wr_phase_off = fscr_fits(i_cmd_wdata, `FSCR_PH_OFF_MAX); // see R5
          next_err     = ~wr_phase_off;
        end
      end
      `FSCR_SEL_OPER_EVENT: begin
        next_data = `FSCR_RST_WORD;                       // see R6
        next_err  = i_cmd_write;
      end
      `FSCR_SEL_OPER_MASK: begin
        next_data = `FSCR_RST_WORD;                       // see R7
        if (i_cmd_write) begin
          next_err = ~fscr_fits(i_cmd_wdata, `FSCR_OPER_MAX); // see R7
        end
      end
      `FSCR_SEL_FAULT_COND: begin
        next_data = fscr_word9(o_fault_cond);             // see R8
        next_err  = i_cmd_write;
      end
      `FSCR_SEL_FAULT_EVENT: begin
        next_data = fscr_word9(fault_event);              // see R9
        next_err  = i_cmd_write;
        clr_event = ~i_cmd_write;                         // see R18
      end
      `FSCR_SEL_FAULT_MASK: begin
        next_data     = fault_event_mask;                 // see R11
        wr_fault_mask = i_cmd_write;
      end
      `FSCR_SEL_FALL_SEL: begin
        next_data   = fall_edge_select;                   // see R15
        wr_fall_sel = i_cmd_write;
      end
      `FSCR_SEL_RISE_SEL: begin
        next_data = fscr_word9(rise_edge_select);         // see R16
        if (i_cmd_write) begin
          wr_rise_sel = fscr_fits(i_cmd_wdata, `FSCR_RISE_MAX);
          next_err    = ~wr_rise_sel;
        end
      end
      `FSCR_SEL_CLEAR: begin
        // Only an accepted clear acts; a refused query leaves events alone
        clr_event = i_cmd_write;                          // see R18
        next_err  = ~i_cmd_write;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
    if (!i_cmd_valid) begin
      clr_event = 1'b0;
    end
  end

  // ----------------------------------------
  // Answer port
  // ----------------------------------------

  // One answer per command, one cycle after it is taken
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_err   <= 1'b0;
      o_rsp_data  <= `FSCR_RST_WORD;
    end else begin
      o_rsp_valid <= i_cmd_valid;
      o_rsp_err   <= i_cmd_valid & next_err;
      o_rsp_data  <= (rd_req & ~next_err) ? next_data : `FSCR_RST_WORD;
    end
  end

  // ----------------------------------------
  // Instrument settings
  // ----------------------------------------

  // Inhibit mode, external control and coupling
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_inhibit_mode <= `FSCR_RST_INHIBIT;
      o_ext_ctl_en   <= `FSCR_RST_EXTERNAL;
      o_coupling_dc  <= `FSCR_RST_COUPLING;
    end else begin
      if (wr_req && wr_inhibit) begin
        o_inhibit_mode <= i_cmd_wdata[1:0];              // see R1
      end
      if (wr_req && wr_external) begin
        o_ext_ctl_en <= i_cmd_wdata[0];                  // see R2
      end
      if (wr_req && wr_coupling) begin
        o_coupling_dc <= i_cmd_wdata[0];                 // see R3
      end
    end
  end

  // Start and stop angles in tenths of a degree
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_phase_on  <= `FSCR_RST_PHASE;
      o_phase_off <= `FSCR_RST_PHASE;
      o_stop_now  <= 1'b0;
    end else begin
      if (wr_req && wr_phase_on) begin
        o_phase_on <= i_cmd_wdata[11:0];                 // see R4
      end
      if (wr_req && wr_phase_off) begin
        o_phase_off <= i_cmd_wdata[11:0];                // see R5
        o_stop_now  <= (i_cmd_wdata[11:0] == `FSCR_STOP_NOW); // see R5
      end
    end
  end

  // ----------------------------------------
  // Fault filter configuration
  // ----------------------------------------

  // Event mask and edge selects, all zero after reset
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_event_mask <= `FSCR_RST_WORD;                // see R19
      fall_edge_select <= `FSCR_RST_WORD;                // see R19
      rise_edge_select <= `FSCR_RST_FLT;                 // see R19
    end else begin
      if (wr_req && wr_fault_mask) begin
        fault_event_mask <= i_cmd_wdata;                 // see R11
      end
      if (wr_req && wr_fall_sel) begin
        fall_edge_select <= i_cmd_wdata;                 // see R15
      end
      if (wr_req && wr_rise_sel) begin
        rise_edge_select <= i_cmd_wdata[8:0];            // see R16
      end
    end
  end

  // ----------------------------------------
  // Fault events and summary
  // ----------------------------------------

  // Sticky events; a new edge wins over a clear in the same cycle
  always @* begin
    next_event = clr_event ? `FSCR_RST_FLT : fault_event;   // see R18
    next_event = next_event | edge_set;                     // see R9
  end

  // Event register, zero after reset
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_event <= `FSCR_RST_FLT;                      // see R19
    end else begin
      fault_event <= next_event;
    end
  end

  // Masked events feed the summary bit when service enable allows
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fault_summary_bit <= 1'b0;
    end else begin
      o_fault_summary_bit <= i_srq_fault_en &
                             (|(fault_event & fault_event_mask[8:0])); // see R10, see R11
    end
  end

endmodule // fscr_regs

// [dv/fscr_regs_properties.sv]
// Port-level concurrent checks for the fault status and settings bank
`timescale 1ns/100ps
module fscr_regs_properties (
  // Clock and reset
  input wire        i_mclk,
  input wire        i_sys_rst,
  // Host command and answer ports
  input wire        i_cmd_valid,
  input wire        i_cmd_write,
  input wire [3:0]  i_cmd_sel,
  input wire [15:0] i_cmd_wdata,
  input wire        o_rsp_valid,
  input wire        o_rsp_err,
  input wire [15:0] o_rsp_data,
  // Fault path and settings
  input wire [8:0]  i_fault_pin,
  input wire        i_srq_fault_en,
  input wire [1:0]  o_inhibit_mode,
  input wire [11:0] o_phase_on,
  input wire [11:0] o_phase_off,
  input wire        o_stop_now,
  input wire [8:0]  o_fault_cond,
  input wire        o_fault_summary_bit
);
  // ----------------------------------------
  // Clocking and building blocks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd(logic [3:0] sel);
    i_cmd_valid && !i_cmd_write && i_cmd_sel == sel;
  endsequence
  sequence s_wr(logic [3:0] sel);
    i_cmd_valid && i_cmd_write && i_cmd_sel == sel;
  endsequence
  // Pins unchanged long enough to pass the synchroniser
  sequence s_pin_steady;
    $stable(i_fault_pin) [*6];
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_oper_event; s_rd(4'h5) |=> o_rsp_valid && o_rsp_data == 16'h0000; endproperty
  property p_oper_mask; s_rd(4'h6) |=> o_rsp_valid && o_rsp_data == 16'h0000; endproperty
  property p_inh_range; o_inhibit_mode != 2'h3; endproperty
  property p_inh_bad;
    s_wr(4'h0) ##0 i_cmd_wdata > 16'h0002 |=> o_rsp_err && $stable(o_inhibit_mode);
  endproperty
  property p_on_max; o_phase_on <= 12'hE0F; endproperty
  property p_on_wr;
    s_wr(4'h3) ##0 i_cmd_wdata <= 16'h0E0F |=> !o_rsp_err && o_phase_on == $past(i_cmd_wdata);
  endproperty
  property p_stop_now; o_stop_now == (o_phase_off == 12'hE10); endproperty
  property p_cond; s_pin_steady |-> o_fault_cond == i_fault_pin; endproperty
  property p_event_w;
    s_rd(4'h8) |=> o_rsp_valid && !o_rsp_err && o_rsp_data[15:9] == 7'h00;
  endproperty
  property p_sum_off; !i_srq_fault_en |=> !o_fault_summary_bit; endproperty
  property p_rise_bad; s_wr(4'hB) ##0 i_cmd_wdata > 16'h01FF |=> o_rsp_err; endproperty

  a_oper_event: assert property (p_oper_event) else $error("oper event not zero");
  a_oper_mask: assert property (p_oper_mask) else $error("oper mask not zero");
  a_inh_range: assert property (p_inh_range) else $error("inhibit mode out of set");
  a_inh_bad: assert property (p_inh_bad) else $error("bad inhibit accepted");
  a_on_max: assert property (p_on_max) else $error("start angle over limit");
  a_on_wr: assert property (p_on_wr) else $error("start angle not stored");
  a_stop_now: assert property (p_stop_now) else $error("stop flag wrong");
  a_cond: assert property (p_cond) else $error("condition not following pins");
  a_event_w: assert property (p_event_w) else $error("event read too wide");
  a_sum_off: assert property (p_sum_off) else $error("summary without enable");
  a_rise_bad: assert property (p_rise_bad) else $error("bad rise select accepted");
endmodule // fscr_regs_properties

// [dv/fscr_host.sv]
// Host controller model that issues commands on the command port
`timescale 1ns/100ps
module fscr_host (
  // Clock
  input  wire        i_mclk,
  // Command port
  output reg         o_valid,
  output reg         o_write,
  output reg  [3:0]  o_sel,
  output reg  [15:0] o_wdata,
  // Answer port
  input  wire        i_rsp_valid,
  input  wire        i_rsp_err,
  input  wire [15:0] i_rsp_data
);
  // Idle port at time zero
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_sel   = 4'h0;
    o_wdata = 16'h0000;
  end
  // One command after gap idle cycles; answer taken in the cycle after the taking edge
  task xfer(input w, input [3:0] s, input [15:0] d, input integer gap,
            output [15:0] rd, output er, output ok);
    begin
      repeat (gap) @(posedge i_mclk);
      @(posedge i_mclk);
      o_valid <= 1'b1;
      o_write <= w;
      o_sel   <= s;
      o_wdata <= d;
      @(posedge i_mclk);
      o_valid <= 1'b0;
      o_wdata <= ~d; // Stale data must not look valid
      @(negedge i_mclk);
      ok = i_rsp_valid;
      er = i_rsp_err;
      rd = i_rsp_data;
    end
  endtask
endmodule // fscr_host

// [dv/fscr_regs_tb.sv]
// Self-checking bench for the fault status and settings bank
`timescale 1ns/100ps
module fscr_regs_tb;
  reg         i_mclk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [8:0]  i_fault_pin = 9'h000;
  reg         i_srq_fault_en = 1'b0;
  wire        cmd_valid, cmd_write, rsp_valid, rsp_err, ext_en, coupling, stop_now, summary;
  wire [3:0]  cmd_sel;
  wire [15:0] cmd_wdata, rsp_data;
  wire [1:0]  inhibit;
  wire [11:0] ph_on, ph_off;
  wire [8:0]  cond;
  integer     err_count = 0;
  integer     cmp_count = 0;
  integer     i;

  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  fscr_regs u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_sel(cmd_sel), .i_cmd_wdata(cmd_wdata),
    .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err), .o_rsp_data(rsp_data),
    .i_fault_pin(i_fault_pin), .i_srq_fault_en(i_srq_fault_en), .o_inhibit_mode(inhibit),
    .o_ext_ctl_en(ext_en), .o_coupling_dc(coupling), .o_phase_on(ph_on),
    .o_phase_off(ph_off), .o_stop_now(stop_now), .o_fault_cond(cond),
    .o_fault_summary_bit(summary));
  fscr_host u_host (.i_mclk(i_mclk), .o_valid(cmd_valid), .o_write(cmd_write),
    .o_sel(cmd_sel), .o_wdata(cmd_wdata), .i_rsp_valid(rsp_valid), .i_rsp_err(rsp_err),
    .i_rsp_data(rsp_data));
  always #4 i_mclk = ~i_mclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Command with expected answer; idle gap is the check count modulo 3, 0 to 2 cycles
  task op(input w, input [3:0] s, input [15:0] d, input [15:0] xd, input xe);
    reg [15:0] rd;
    reg        er;
    reg        ok;
    begin
      u_host.xfer(w, s, d, cmp_count % 3, rd, er, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(rd, xd);
      chk({15'h0000, er}, {15'h0000, xe});
    end
  endtask
  // Good write, refused write, then read back
  task rw(input [3:0] s, input [15:0] g, input [15:0] b, input [15:0] back);
    begin
      op(1'b1, s, g, 16'h0000, 1'b0);
      op(1'b1, s, b, 16'h0000, 1'b1);
      op(1'b0, s, 16'h0000, back, 1'b0);
    end
  endtask
  task pins(input [8:0] v);
    begin
      @(posedge i_mclk) i_fault_pin <= v;
      repeat (8) @(posedge i_mclk);
    end
  endtask
  task en_set(input v);
    begin
      @(posedge i_mclk) i_srq_fault_en <= v;
      @(posedge i_mclk);
      @(negedge i_mclk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (i = 0; i < 12; i = i + 1)
      op(1'b0, i[3:0], 16'h0000, 16'h0000, 1'b0);
    $display("test reset values done");
    rw(4'h0, 16'h0000, 16'h0003, 16'h0000);
    rw(4'h0, 16'h0001, 16'h0003, 16'h0001);
    rw(4'h0, 16'h0002, 16'h0003, 16'h0002);
    chk({14'h0000, inhibit}, 16'h0002);
    rw(4'h1, 16'h0001, 16'h0002, 16'h0001);
    rw(4'h2, 16'h0001, 16'h0002, 16'h0001);
    chk({14'h0000, ext_en, coupling}, 16'h0003);
    rw(4'h3, 16'h0E0F, 16'h0E10, 16'h0E0F);
    rw(4'h4, 16'h0E10, 16'h0E11, 16'h0E10);
    chk({3'h0, stop_now, ph_on}, 16'h1E0F);
    chk({4'h0, ph_off}, 16'h0E10);
    rw(4'h6, 16'h00FF, 16'h0100, 16'h0000);
    rw(4'hB, 16'h01FF, 16'h0200, 16'h01FF);
    op(1'b1, 4'hA, 16'hFFFF, 16'h0000, 1'b0);
    op(1'b0, 4'hA, 16'h0000, 16'hFFFF, 1'b0);
    op(1'b1, 4'h9, 16'hFFFF, 16'h0000, 1'b0);
    op(1'b0, 4'h9, 16'h0000, 16'hFFFF, 1'b0);
    op(1'b1, 4'h5, 16'h0001, 16'h0000, 1'b1);
    op(1'b1, 4'h7, 16'h0001, 16'h0000, 1'b1);
    op(1'b1, 4'h8, 16'h0001, 16'h0000, 1'b1);
    op(1'b0, 4'hC, 16'h0000, 16'h0000, 1'b1);
    $display("test settings done");
    op(1'b1, 4'hB, 16'h0100, 16'h0000, 1'b0);
    op(1'b1, 4'hA, 16'h0001, 16'h0000, 1'b0);
    op(1'b1, 4'h9, 16'h0000, 16'h0000, 1'b0);
    pins(9'h120);
    chk({7'h00, cond}, 16'h0120);
    op(1'b0, 4'h7, 16'h0000, 16'h0120, 1'b0);
    op(1'b0, 4'h8, 16'h0000, 16'h0100, 1'b0);
    op(1'b0, 4'h8, 16'h0000, 16'h0000, 1'b0);
    pins(9'h121);
    op(1'b0, 4'h8, 16'h0000, 16'h0000, 1'b0);
    pins(9'h120);
    op(1'b0, 4'hC, 16'h0000, 16'h0000, 1'b1);
    en_set(1'b1);
    chk({15'h0000, summary}, 16'h0000);
    op(1'b1, 4'h9, 16'h0001, 16'h0000, 1'b0);
    @(negedge i_mclk);
    chk({15'h0000, summary}, 16'h0001);
    en_set(1'b0);
    chk({15'h0000, summary}, 16'h0000);
    en_set(1'b1);
    chk({15'h0000, summary}, 16'h0001);
    op(1'b1, 4'hC, 16'h0000, 16'h0000, 1'b0);
    @(negedge i_mclk);
    chk({15'h0000, summary}, 16'h0000);
    op(1'b0, 4'h8, 16'h0000, 16'h0000, 1'b0);
    $display("test fault path done");
    summarize;
  end

  // Watchdog against a hung command port
  initial begin
    #200000;
    err_count = err_count + 1;
    $display("BAD %0t watchdog expired", $time);
    summarize;
  end
endmodule // fscr_regs_tb

bind fscr_regs fscr_regs_properties u_props (
  .i_mclk              (i_mclk),
  .i_sys_rst           (i_sys_rst),
  .i_cmd_valid         (i_cmd_valid),
  .i_cmd_write         (i_cmd_write),
  .i_cmd_sel           (i_cmd_sel),
  .i_cmd_wdata         (i_cmd_wdata),
  .o_rsp_valid         (o_rsp_valid),
  .o_rsp_err           (o_rsp_err),
  .o_rsp_data          (o_rsp_data),
  .i_fault_pin         (i_fault_pin),
  .i_srq_fault_en      (i_srq_fault_en),
  .o_inhibit_mode      (o_inhibit_mode),
  .o_phase_on          (o_phase_on),
  .o_phase_off         (o_phase_off),
  .o_stop_now          (o_stop_now),
  .o_fault_cond        (o_fault_cond),
  .o_fault_summary_bit (o_fault_summary_bit)
);
